// File: conv_pkg.sv
// shared constants and types for the converter control block
package conv_pkg;
   // register byte addresses (APB, one aligned word each)
   localparam logic [7:0] addr_conv_control = 8'h00;
   localparam logic [7:0] addr_conv_clock_config = 8'h04;
   localparam logic [7:0] addr_result_high_byte = 8'h08;
   localparam logic [7:0] addr_result_low_byte = 8'h0c;
   localparam logic [7:0] addr_irq_status = 8'h10;
   localparam logic [7:0] addr_irq_mask = 8'h14;
   // conv_control fields
   localparam int pos_result_justify = 7;
   localparam int pos_ref_select = 6;
   localparam int pos_chan_hi = 5;
   localparam int pos_chan_lo = 2;
   localparam int pos_go = 1;
   localparam int pos_converter_on = 0;
   // conv_clock_config field
   localparam int pos_div_hi = 6;
   localparam int pos_div_lo = 4;
   localparam logic [7:0] clock_config_mask = 8'h70;
   localparam logic [7:0] control_reset = 8'h00;
   localparam logic [7:0] clock_config_reset = 8'h00;
   // channel codes
   localparam logic [3:0] chan_last_input = 4'hb;
   localparam logic [3:0] chan_comparator_ref = 4'hc;
   localparam logic [3:0] chan_fixed_ref = 4'hd;
   // timing
   localparam int bits_per_result = 10;
   localparam int periods_per_conversion = 11;
   localparam int abort_wait_periods = 2;
   localparam int rc_start_delay_cycles = 4;
   localparam int clk_hz = 25_000_000;
   localparam int rc_max_hz = 500_000;
   localparam int rc_half_cycles = (clk_hz + 2 * rc_max_hz - 1) / (2 * rc_max_hz);
   typedef enum logic [3:0] {
      st_idle = 4'b0001,
      st_delay = 4'b0010,
      st_convert = 4'b0100,
      st_abort = 4'b1000
   } conv_state_t;
endpackage

// File: tick_if.sv
// bit-period tick carrier between the controller and its clock divider
`timescale 1ns/10ps
interface tick_if;
   logic [2:0] div_code;
   logic run;
   logic tick;
   modport ctrl (output div_code, output run, input tick);
   modport gen (input div_code, input run, output tick);
endinterface

// File: bit_period_gen.sv
// conversion clock: system clock divider or internal rc-like oscillator
`timescale 1ns/10ps
module bit_period_gen
   import conv_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   tick_if.gen tk
);
   logic [6:0] count;
   logic [6:0] limit;
   // half-period for the internal oscillator: a full period is two halves
   function automatic logic [6:0] div_limit(input logic [2:0] code);
      case (code)
         3'b000: div_limit = 7'd1;
         3'b001: div_limit = 7'd7;
         3'b010: div_limit = 7'd31;
         3'b100: div_limit = 7'd3;
         3'b101: div_limit = 7'd15;
         3'b110: div_limit = 7'd63;
         default: div_limit = 7'((2 * rc_half_cycles) - 1);
      endcase
   endfunction
   assign limit = div_limit(tk.div_code);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 7'd0;
         tk.tick <= 1'b0;
      end else if (!tk.run) begin
         count <= 7'd0;
         tk.tick <= 1'b0;
      end else if (count >= limit) begin
         count <= 7'd0;
         tk.tick <= 1'b1;
      end else begin
         count <= count + 7'd1;
         tk.tick <= 1'b0;
      end
   end
endmodule

// File: conv_ctrl.sv
// converter control and result registers with apb slave and interrupt
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module conv_ctrl
   import conv_pkg::*;
#(
   parameter int addr_width = 8
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [addr_width-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [9:0] sar_result,
   output logic sar_sample,
   output logic sar_bit_strobe,
   output logic converter_on,
   output logic ref_select,
   output logic [3:0] channel_select,
   output logic acquiring,
   output logic conv_done_irq
);
   // ======================================================
   // registers and state
   logic [7:0] conv_control;
   logic [7:0] conv_clock_config;
   logic [7:0] result_high_byte;
   logic [7:0] result_low_byte;
   logic conv_done_flag;
   logic conv_done_irq_enable;
   conv_state_t state;
   logic [3:0] period_count;
   logic [2:0] delay_count;
   logic [9:0] result_held;
   logic result_loaded;
   logic go_seen;
   logic wr_access;
   logic rd_access;
   logic wr_lane0;
   logic conv_finish;
   logic go_clear_sw;
   logic go_set_sw;
   logic rc_selected;
   tick_if tk();

   bit_period_gen u_bit_period_gen (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .tk(tk)
   );

   // ======================================================
   // apb decode
   function automatic logic hit(input logic [addr_width-1:0] a, input logic [7:0] off);
      hit = (a == addr_width'(off));
   endfunction

   assign wr_access = psel && penable && pwrite && pready;
   assign rd_access = psel && !penable && !pwrite;
   assign wr_lane0 = wr_access && pstrb[0];
   assign rc_selected = (conv_clock_config[pos_div_lo+1:pos_div_lo] == 2'b11);
   assign go_set_sw = wr_lane0 && hit(paddr, addr_conv_control) && pwdata[pos_go]
      && !conv_control[pos_go];
   assign go_clear_sw = wr_lane0 && hit(paddr, addr_conv_control) && !pwdata[pos_go]
      && conv_control[pos_go];
   assign conv_finish = (state == st_convert) && tk.tick
      && (period_count == 4'(periods_per_conversion - 1)) && !go_clear_sw;

   // no wait state: setup cycle fetches data, first access cycle completes
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && !penable;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         if (hit(paddr, addr_conv_control) || hit(paddr, addr_conv_clock_config)
            || hit(paddr, addr_result_high_byte) || hit(paddr, addr_result_low_byte)
            || hit(paddr, addr_irq_status) || hit(paddr, addr_irq_mask)) begin
            pslverr <= 1'b0;
         end else begin
            pslverr <= 1'b1;
         end
      end else begin
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (rd_access) begin
         if (hit(paddr, addr_conv_control)) begin
            prdata <= {24'h00_0000, conv_control};
         end else if (hit(paddr, addr_conv_clock_config)) begin
            prdata <= {24'h00_0000, conv_clock_config & clock_config_mask};
         end else if (hit(paddr, addr_result_high_byte)) begin
            prdata <= {24'h00_0000, result_high_byte};
         end else if (hit(paddr, addr_result_low_byte)) begin
            prdata <= {24'h00_0000, result_low_byte};
         end else if (hit(paddr, addr_irq_status)) begin
            prdata <= {31'h0000_0000, conv_done_flag};
         end else if (hit(paddr, addr_irq_mask)) begin
            prdata <= {31'h0000_0000, conv_done_irq_enable};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ======================================================
   // control registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_control <= control_reset;
      end else begin
         if (wr_lane0 && hit(paddr, addr_conv_control)) begin
            conv_control <= pwdata[7:0];
         end
         // a go the sequencer cannot take must not read as running forever
         if (go_set_sw && (state != st_idle || !conv_control[pos_converter_on])) begin
            conv_control[pos_go] <= 1'b0;
         end
         // finish wins over a same-cycle software write of one
         if (conv_finish) begin
            conv_control[pos_go] <= 1'b0;
         end
         if (!conv_control[pos_converter_on] && !(wr_lane0
            && hit(paddr, addr_conv_control) && pwdata[pos_converter_on])) begin
            conv_control[pos_go] <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_clock_config <= clock_config_reset;
      end else if (wr_lane0 && hit(paddr, addr_conv_clock_config)) begin
         conv_clock_config <= pwdata[7:0] & clock_config_mask;
      end
   end

   // ======================================================
   // conversion sequencer
   assign tk.div_code = conv_clock_config[pos_div_hi:pos_div_lo];
   assign tk.run = conv_control[pos_converter_on] && (state != st_idle);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= st_idle;
         period_count <= 4'h0;
         delay_count <= 3'h0;
      end else if (!conv_control[pos_converter_on]) begin
         state <= st_idle;
         period_count <= 4'h0;
         delay_count <= 3'h0;
      end else begin
         case (state)
            st_idle: begin
               period_count <= 4'h0;
               if (go_set_sw) begin
                  if (rc_selected) begin
                     state <= st_delay;
                     delay_count <= 3'(rc_start_delay_cycles - 1);
                  end else begin
                     state <= st_convert;
                  end
               end
            end
            st_delay: begin
               if (go_clear_sw) begin
                  state <= st_idle;
               end else if (delay_count == 3'h0) begin
                  state <= st_convert;
               end else begin
                  delay_count <= delay_count - 3'h1;
               end
            end
            st_convert: begin
               if (go_clear_sw) begin
                  state <= st_abort;
                  period_count <= 4'h0;
               end else if (tk.tick) begin
                  if (period_count == 4'(periods_per_conversion - 1)) begin
                     state <= st_idle;
                     period_count <= 4'h0;
                  end else begin
                     period_count <= period_count + 4'h1;
                  end
               end
            end
            st_abort: begin
               if (tk.tick) begin
                  if (period_count == 4'(abort_wait_periods - 1)) begin
                     state <= st_idle;
                     period_count <= 4'h0;
                  end else begin
                     period_count <= period_count + 4'h1;
                  end
               end
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // ======================================================
   // analog-side controls
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         converter_on <= 1'b0;
         ref_select <= 1'b0;
         channel_select <= 4'h0;
         acquiring <= 1'b0;
         sar_sample <= 1'b0;
         sar_bit_strobe <= 1'b0;
      end else begin
         converter_on <= conv_control[pos_converter_on];
         ref_select <= conv_control[pos_ref_select];
         channel_select <= conv_control[pos_chan_hi:pos_chan_lo];
         // hold capacitor tracks the channel while the converter is on and no conversion or abort wait runs
         acquiring <= conv_control[pos_converter_on]
            && (state == st_idle || state == st_delay);
         sar_sample <= (state == st_convert) && tk.tick && (period_count == 4'h0);
         sar_bit_strobe <= (state == st_convert) && tk.tick
            && (period_count != 4'h0);
      end
   end

   // ======================================================
   // result bytes: no reset, contents undefined at power-on
   always_ff @(posedge core_clk) begin
      if (conv_finish) begin
         result_held <= sar_result;
      end else if (wr_lane0 && hit(paddr, addr_result_high_byte)) begin
         if (conv_control[pos_result_justify]) begin
            result_held[9:8] <= pwdata[1:0];
         end else begin
            result_held[9:2] <= pwdata[7:0];
         end
      end else if (wr_lane0 && hit(paddr, addr_result_low_byte)) begin
         if (conv_control[pos_result_justify]) begin
            result_held[7:0] <= pwdata[7:0];
         end else begin
            result_held[1:0] <= pwdata[7:6];
         end
      end
   end

   // layout follows the justify bit at read time; reserved bits read zero
   always_comb begin
      if (conv_control[pos_result_justify]) begin
         result_high_byte = {6'h00, result_held[9:8]};
         result_low_byte = result_held[7:0];
      end else begin
         result_high_byte = result_held[9:2];
         result_low_byte = {result_held[1:0], 6'h00};
      end
   end

   // ======================================================
   // interrupt: sticky flag, write one to clear, set wins
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_done_flag <= 1'b0;
      end else if (conv_finish) begin
         conv_done_flag <= 1'b1;
      end else if (wr_lane0 && hit(paddr, addr_irq_status) && pwdata[0]) begin
         conv_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_done_irq_enable <= 1'b0;
      end else if (wr_lane0 && hit(paddr, addr_irq_mask)) begin
         conv_done_irq_enable <= pwdata[0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         conv_done_irq <= 1'b0;
      end else begin
         conv_done_irq <= conv_done_flag && conv_done_irq_enable;
      end
   end
endmodule

// File: conv_ctrl_checker.sv
// concurrent checks on the converter control block ports
`timescale 1ns/10ps
module conv_ctrl_checker
   import conv_pkg::*;
#(
   parameter int addr_width = 8
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [addr_width-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sar_sample,
   input wire logic sar_bit_strobe,
   input wire logic converter_on,
   input wire logic ref_select,
   input wire logic [3:0] channel_select,
   input wire logic acquiring,
   input wire logic conv_done_irq
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic wr_ok;
   logic [3:0] n_strobe;
   // ======
   // helper logic
   assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         n_strobe <= 4'h0;
      end else if (sar_sample) begin
         n_strobe <= 4'h0;
      end else if (sar_bit_strobe) begin
         n_strobe <= n_strobe + 4'h1;
      end
   end
   // ======
   // assertions
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_chan_ref_copy: assert property (wr_ok && paddr == addr_conv_control |-> ##2
      channel_select == $past(pwdata[5:2], 2) && ref_select == $past(pwdata[6], 2))
      else $error("channel or reference not taken");
   a_enable_copy: assert property (wr_ok && paddr == addr_conv_control |->
      ##2 converter_on == $past(pwdata[0], 2)) else $error("enable not taken");
   a_off_no_acq: assert property (!converter_on && !$past(converter_on) &&
      !$past(converter_on, 2) |-> !$past(acquiring)) else $error("acquiring while off");
   a_strobe_bound: assert property (n_strobe <= 4'ha)
      else $error("too many bit strobes");
   a_strobe_gap: assert property (sar_bit_strobe |=> !sar_bit_strobe)
      else $error("bit period below two clocks");
   a_sample_gap: assert property (sar_sample |=> !sar_sample && !sar_bit_strobe)
      else $error("sample period below two clocks");
   a_irq_masked: assert property (wr_ok && paddr == addr_irq_mask && !pwdata[0] |->
      ##2 !conv_done_irq) else $error("interrupt while masked");
endmodule

bind conv_ctrl conv_ctrl_checker #(.addr_width(addr_width)) u_conv_ctrl_checker (.core_clk,
   .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
   .sar_sample, .sar_bit_strobe, .converter_on, .ref_select, .channel_select, .acquiring,
   .conv_done_irq);

// File: conv_ctrl_tb_top.sv
// self-checking testbench for the converter control block
`timescale 1ns/10ps
module conv_ctrl_tb_top;
   import conv_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [9:0] sar_result = 10'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, sar_sample, sar_bit_strobe, converter_on, ref_select, acquiring, irq;
   logic err;
   logic [3:0] channel_select;
   logic [9:0] last_v;
   int num_errors = 0, n_checks = 0, cyc = 0, gap = 0, last_gap = 0, n_strobe = 0;

   conv_ctrl u_conv_ctrl (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .sar_result, .sar_sample, .sar_bit_strobe,
      .converter_on, .ref_select, .channel_select, .acquiring, .conv_done_irq(irq));

   initial forever #20 core_clk = ~core_clk;

   // ======
   // monitors and hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      gap <= sar_bit_strobe ? 1 : gap + 1;
      if (sar_bit_strobe) last_gap <= gap;
      if (sar_sample) n_strobe <= 0;
      else if (sar_bit_strobe) n_strobe <= n_strobe + 1;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop;
      end
   end

   // ======
   // bus and check helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk(rd, exp);
   endtask

   task automatic report_and_stop;
      $display("errors=%0d checks=%0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ======
   // scenarios
   task automatic t_reset;
      rchk(addr_conv_control, 32'h0);
      rchk(addr_conv_clock_config, 32'h0);
      apb(8'h18, 1'b1, 32'hff);
      chk({31'h0, err}, 32'h1);
      rchk(8'h18, 32'h0);
      apb(addr_conv_clock_config, 1'b1, 32'hff);
      rchk(addr_conv_clock_config, 32'h70);
   endtask

   task automatic run(input logic [7:0] c);
      apb(addr_conv_control, 1'b1, {24'h0, c});
      repeat (20) @(posedge core_clk);
      apb(addr_conv_control, 1'b1, {24'h0, c | 8'h02});
      apb(addr_conv_control, 1'b0, 32'h0);
      chk({31'h0, rd[1]}, 32'h1);
      while (rd[1]) apb(addr_conv_control, 1'b0, 32'h0);
   endtask

   task automatic t_divider;
      int per[8] = '{2, 8, 32, 50, 4, 16, 64, 50};
      for (int i = 0; i < 8; i++) begin
         last_v = 10'h2a5 ^ (10'h3 << i);
         sar_result <= last_v;
         apb(addr_irq_mask, 1'b1, {31'h0, i[0]});
         apb(addr_conv_clock_config, 1'b1, {25'h0, i[2:0], 4'hf});
         run(8'h81 | 8'(i << 2));
         chk(last_gap, per[i]);
         chk(n_strobe, 10);
         rchk(addr_result_high_byte, {30'h0, last_v[9:8]});
         rchk(addr_result_low_byte, {24'h0, last_v[7:0]});
         rchk(addr_irq_status, 32'h1);
         chk({31'h0, irq}, {31'h0, i[0]});
         apb(addr_irq_status, 1'b1, 32'h1);
         rchk(addr_irq_status, 32'h0);
         chk({31'h0, irq}, 32'h0);
      end
   endtask

   task automatic t_layout;
      apb(addr_conv_control, 1'b1, 32'h01);
      rchk(addr_result_high_byte, {24'h0, last_v[9:2]});
      apb(addr_result_low_byte, 1'b0, 32'h0);
      chk(rd & 32'hc0, {24'h0, last_v[1:0], 6'h0});
   endtask

   task automatic t_abort;
      apb(addr_conv_clock_config, 1'b1, 32'h60);
      sar_result <= 10'h155;
      apb(addr_conv_control, 1'b1, 32'h83);
      // clearing go mid conversion aborts it; long bit period keeps it from finishing first
      apb(addr_conv_control, 1'b1, 32'h81);
      rchk(addr_conv_control, 32'h81);
      repeat (800) @(posedge core_clk);
      rchk(addr_result_low_byte, {24'h0, last_v[7:0]});
      rchk(addr_irq_status, 32'h0);
      chk({31'h0, acquiring}, 32'h1);
   endtask

   task automatic t_fields;
      logic [7:0] b;
      for (int c = 0; c < 14; c++) begin
         b = {1'b0, c[1], c[3:0], 1'b0, c[0]};
         apb(addr_conv_control, 1'b1, {24'h0, b});
         repeat (2) @(posedge core_clk);
         chk({26'h0, ref_select, channel_select, converter_on}, {26'h0, b[6:2], b[0]});
         chk({31'h0, acquiring}, {31'h0, b[0]});
         rchk(addr_conv_control, {24'h0, b});
      end
   endtask

   // ======
   // main sequence
   initial begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      t_reset;
      t_divider;
      t_layout;
      t_abort;
      t_fields;
      // results must outlive a second reset
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      rchk(addr_conv_control, 32'h0);
      rchk(addr_result_high_byte, {24'h0, last_v[9:2]});
      report_and_stop;
   end
endmodule
